/* hdl/vcps_exec.v */
// execution unit for voice channel play, stop and skip operations
`timescale 1ns/10ps
`default_nettype none
`include "vcps_defs.vh"

// Notes on behaviour
// - every channel operation acts on the channel_select register value
// - channel-idle skip discards next instruction when head and tail idle
// - channel-active skip discards next instruction if head or tail plays
// - all-idle skip discards next instruction only when no channel plays
// - head-idle skip discards next instruction when head wave is idle
// - head-active skip discards next instruction when head wave plays
// - skips take one cycle, or two to four when a skip occurs
// - stop halts selected channel playback in one cycle, data to midpoint
// - immediate play loads 22-bit head pointer and starts head playback
// - immediate play is three words long and takes four cycles
// - immediate tail load: 22-bit tail pointer, three words, four cycles
// - both tail loads stop the channel before storing the tail pointer

module vcps_exec
#(
  parameter CHANNELS = 8,
  parameter CH_W = 3
)
(
  input wire mclk_in, // core system clock, 20 MHz
  input wire reset_n_in, // asynchronous reset, active low
  input wire op_valid_in, // one-cycle strobe: op_code_in is a new operation
  input wire [3:0] op_code_in, // decoded operation
  input wire [CH_W-1:0] channel_select_in, // channel_select register value
  input wire [`VCPS_HALF_W-1:0] operand_in, // operand word, cycles 1 and 2
  input wire [`VCPS_PTR_W-1:0] reg_ptr_in, // pointer register value
  input wire [1:0] next_words_in, // length of the following instruction
  input wire [CHANNELS-1:0] head_active_in, // synth head wave playing
  input wire [CHANNELS-1:0] tail_active_in, // synth tail wave playing
  output wire busy_out, // operation in progress, core stalls
  output reg skip_out, // pulse: next instruction discarded
  output reg discard_out, // level: core squashes this word
  output reg stop_out, // pulse: stop selected channel
  output reg start_head_out, // pulse: start head wave playback
  output reg head_ptr_we_out, // pulse: write head pointer
  output reg tail_ptr_we_out, // pulse: write tail pointer
  output reg [CH_W-1:0] target_chan_out, // channel for stop, start, writes
  output reg [`VCPS_PTR_W-1:0] ptr_data_out, // pointer write data
  output reg [11:0] chan_data_out // data level forced on stop
);

  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_IMM1 = 6'h02;
  localparam [5:0] ST_IMM2 = 6'h04;
  localparam [5:0] ST_COMMIT = 6'h08;
  localparam [5:0] ST_DISCARD = 6'h10;
  localparam [5:0] ST_TAIL_REG = 6'h20;

  reg [5:0] state;
  reg [5:0] next_state;
  reg [1:0] discard_left;
  reg [1:0] next_discard_left;
  reg is_tail;
  reg [`VCPS_HALF_W-1:0] hi_word;
  reg [CH_W-1:0] chan_hold;
  reg [`VCPS_PTR_W-1:0] reg_hold;

  wire chan_active;
  wire head_active;
  wire any_active;
  reg skip_now;

  // ------------------------------------------------------------
  // play state of the selected channel
  // ------------------------------------------------------------
  vcps_chan_status #(
    .CHANNELS(CHANNELS),
    .CH_W(CH_W)
  ) u_status (
    .head_active_in(head_active_in),
    .tail_active_in(tail_active_in),
    .channel_in(channel_select_in),
    .chan_active_out(chan_active),
    .head_active_out(head_active),
    .any_active_out(any_active)
  );

  // ------------------------------------------------------------
  // skip condition
  // ------------------------------------------------------------
  always @*
  begin
    case (op_code_in)
      `VCPS_OP_SKIP_IF_CHANNEL_IDLE: skip_now = ~chan_active;
      `VCPS_OP_SKIP_IF_CHANNEL_ACTIVE: skip_now = chan_active;
      `VCPS_OP_SKIP_IF_ALL_IDLE: skip_now = ~any_active;
      `VCPS_OP_SKIP_IF_HEAD_IDLE: skip_now = ~head_active;
      `VCPS_OP_SKIP_IF_HEAD_ACTIVE: skip_now = head_active;
      default: skip_now = 1'b0;
    endcase
  end

  wire take_op;
  assign take_op = op_valid_in & state[0];

  // stall the core after the first cycle of any multi-cycle operation
  assign busy_out = ~state[0];

  // ------------------------------------------------------------
  // sequencing
  // ------------------------------------------------------------
  always @*
  begin
    next_state = state;
    next_discard_left = discard_left;
    case (state)
      ST_IDLE:
      begin
        if (take_op)
        begin
          if (skip_now)
          begin
            // a zero length means a one-word instruction
            next_state = ST_DISCARD;
            next_discard_left = (next_words_in == 2'd0) ?
              2'd1 : next_words_in;
          end
          else if (op_code_in == `VCPS_OP_START_HEAD_IMMEDIATE ||
                   op_code_in == `VCPS_OP_LOAD_TAIL_IMMEDIATE)
          begin
            next_state = ST_IMM1;
          end
          else if (op_code_in == `VCPS_OP_LOAD_TAIL_FROM_REGISTER)
          begin
            next_state = ST_TAIL_REG;
          end
        end
      end
      ST_IMM1: next_state = ST_IMM2;
      ST_IMM2: next_state = ST_COMMIT;
      ST_COMMIT: next_state = ST_IDLE;
      ST_TAIL_REG: next_state = ST_IDLE;
      ST_DISCARD:
      begin
        // every word of the discarded instruction is squashed
        next_discard_left = discard_left - 2'd1;
        if (discard_left == 2'd1)
        begin
          next_state = ST_IDLE;
        end
      end
      default:
      begin
        next_state = ST_IDLE;
        next_discard_left = 2'd0;
      end
    endcase
  end

  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state <= ST_IDLE;
      discard_left <= 2'd0;
    end
    else
    begin
      state <= next_state;
      discard_left <= next_discard_left;
    end
  end

  // ------------------------------------------------------------
  // operand capture and synthesizer commands
  // ------------------------------------------------------------
  always @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      is_tail <= 1'b0;
      hi_word <= {`VCPS_HALF_W{1'b0}};
      chan_hold <= {CH_W{1'b0}};
      reg_hold <= `VCPS_PTR_RESET;
      skip_out <= 1'b0;
      discard_out <= 1'b0;
      stop_out <= 1'b0;
      start_head_out <= 1'b0;
      head_ptr_we_out <= 1'b0;
      tail_ptr_we_out <= 1'b0;
      target_chan_out <= {CH_W{1'b0}};
      ptr_data_out <= `VCPS_PTR_RESET;
      chan_data_out <= `VCPS_MID_LEVEL;
    end
    else
    begin
      skip_out <= take_op & skip_now;
      discard_out <= next_state[4];
      stop_out <= 1'b0;
      start_head_out <= 1'b0;
      head_ptr_we_out <= 1'b0;
      tail_ptr_we_out <= 1'b0;
      if (take_op)
      begin
        // channel latched at issue; later changes do not retarget
        chan_hold <= channel_select_in;
        reg_hold <= reg_ptr_in;
        is_tail <= (op_code_in == `VCPS_OP_LOAD_TAIL_IMMEDIATE);
        if (op_code_in == `VCPS_OP_STOP ||
            op_code_in == `VCPS_OP_LOAD_TAIL_IMMEDIATE ||
            op_code_in == `VCPS_OP_LOAD_TAIL_FROM_REGISTER)
        begin
          // tail loads stop the voice ahead of the pointer write
          stop_out <= 1'b1;
          target_chan_out <= channel_select_in;
          chan_data_out <= `VCPS_MID_LEVEL;
        end
      end
      if (state[1])
      begin
        hi_word <= operand_in;
      end
      if (state[2])
      begin
        // operand assembled now, written out at the end of commit
        ptr_data_out <= {hi_word, operand_in};
        target_chan_out <= chan_hold;
      end
      if (state[3])
      begin
        head_ptr_we_out <= ~is_tail;
        start_head_out <= ~is_tail;
        tail_ptr_we_out <= is_tail;
      end
      if (state[5])
      begin
        ptr_data_out <= reg_hold;
        target_chan_out <= chan_hold;
        tail_ptr_we_out <= 1'b1;
      end
    end
  end

endmodule // vcps_exec

`default_nettype wire

/* include/vcps_defs.vh */
// constants of the voice channel play and skip execution unit
`ifndef VCPS_DEFS_VH
`define VCPS_DEFS_VH

// channel_select register location in the core data space
`define VCPS_CHSEL_ADDR 8'h12

// operation codes presented on op_code_in
`define VCPS_OP_NONE 4'h0
`define VCPS_OP_SKIP_IF_CHANNEL_IDLE 4'h1
`define VCPS_OP_SKIP_IF_CHANNEL_ACTIVE 4'h2
`define VCPS_OP_SKIP_IF_ALL_IDLE 4'h3
`define VCPS_OP_SKIP_IF_HEAD_IDLE 4'h4
`define VCPS_OP_SKIP_IF_HEAD_ACTIVE 4'h5
`define VCPS_OP_STOP 4'h6
`define VCPS_OP_START_HEAD_IMMEDIATE 4'h7
`define VCPS_OP_LOAD_TAIL_IMMEDIATE 4'h8
`define VCPS_OP_LOAD_TAIL_FROM_REGISTER 4'h9

// pointer layout: two operand words of 11 bits, high word first
`define VCPS_PTR_W 22
`define VCPS_HALF_W 11
`define VCPS_PTR_MAX 22'h3fffff

// word counts and cycle counts
`define VCPS_IMM_WORDS 3
`define VCPS_IMM_CYCLES 4
`define VCPS_SKIP_BASE_CYCLES 1

// reset values
`define VCPS_PTR_RESET 22'h000000
`define VCPS_MID_LEVEL 12'h800

`endif

/* hdl/vcps_chan_status.v */
// play state tests for the selected channel
`timescale 1ns/10ps
`default_nettype none

module vcps_chan_status
#(
  parameter CHANNELS = 8,
  parameter CH_W = 3
)
(
  input wire [CHANNELS-1:0] head_active_in, // head wave playing, per channel
  input wire [CHANNELS-1:0] tail_active_in, // tail wave playing, per channel
  input wire [CH_W-1:0] channel_in, // selected channel
  output wire chan_active_out, // head or tail playing
  output wire head_active_out, // head playing
  output wire any_active_out // some channel playing
);

  // ------------------------------------------------------------
  // channel select decode
  // ------------------------------------------------------------
  function [CHANNELS-1:0] vcps_onehot;
    input [CH_W-1:0] ch;
    begin
      vcps_onehot = {{(CHANNELS-1){1'b0}}, 1'b1} << ch;
    end
  endfunction

  wire [CHANNELS-1:0] sel;
  assign sel = vcps_onehot(channel_in);

  // out-of-range channel numbers select nothing and read idle
  assign head_active_out = |(sel & head_active_in);
  assign chan_active_out = |(sel & (head_active_in | tail_active_in));
  assign any_active_out = |(head_active_in | tail_active_in);

endmodule // vcps_chan_status

`default_nettype wire

/* test/vcps_exec_monitor.sv */
// checker for the voice play and skip unit
`timescale 1ns/10ps
`default_nettype none
module vcps_exec_monitor
#(
  parameter CHANNELS = 8,
  parameter CH_W = 3
)
(
  input wire logic mclk_in, // clock
  input wire logic reset_n_in, // reset
  input wire logic op_valid_in, // strobe
  input wire logic [3:0] op_code_in, // op
  input wire logic [CH_W-1:0] channel_select_in, // channel
  input wire logic [21:0] reg_ptr_in, // reg pointer
  input wire logic [CHANNELS-1:0] head_active_in, // head
  input wire logic [CHANNELS-1:0] tail_active_in, // tail
  input wire logic busy_out, // busy
  input wire logic skip_out, // skip
  input wire logic discard_out, // squash
  input wire logic stop_out, // stop
  input wire logic start_head_out, // start
  input wire logic head_ptr_we_out, // head write
  input wire logic tail_ptr_we_out, // tail write
  input wire logic [CH_W-1:0] target_chan_out, // target
  input wire logic [21:0] ptr_data_out, // pointer
  input wire logic [11:0] chan_data_out // level
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);
  wire tk = op_valid_in && !busy_out;
  wire hd = head_active_in[channel_select_in];
  wire ch = hd | tail_active_in[channel_select_in];
  wire anyp = |(head_active_in | tail_active_in);

  a_chan_idle_skip:
    assert property (tk && op_code_in == 4'h1 |=> skip_out == !$past(ch))
    else $error("channel idle skip wrong");
  a_chan_act_skip:
    assert property (tk && op_code_in == 4'h2 |=> skip_out == $past(ch))
    else $error("channel active skip wrong");
  a_all_idle_skip:
    assert property (tk && op_code_in == 4'h3 |=> skip_out == !$past(anyp))
    else $error("all idle skip wrong");
  a_head_idle_skip:
    assert property (tk && op_code_in == 4'h4 |=> skip_out == !$past(hd))
    else $error("head idle skip wrong");
  a_head_act_skip:
    assert property (tk && op_code_in == 4'h5 |=> skip_out == $past(hd))
    else $error("head active skip wrong");
  a_skip_len:
    assert property (skip_out |-> discard_out && busy_out ##[1:3] !busy_out)
    else $error("skip length wrong");
  a_stop_mid:
    assert property (tk && op_code_in == 4'h6 |=> stop_out &&
      chan_data_out == 12'h800 && target_chan_out == $past(channel_select_in))
    else $error("stop wrong");
  a_play_imm:
    assert property (tk && op_code_in == 4'h7 |=> !head_ptr_we_out [*3]
      ##1 head_ptr_we_out && start_head_out)
    else $error("immediate play timing wrong");
  a_tail_imm:
    assert property (tk && op_code_in == 4'h8 |=> stop_out ##3 tail_ptr_we_out)
    else $error("immediate tail load wrong");
  a_tail_reg:
    assert property (tk && op_code_in == 4'h9 |=> stop_out ##1
      tail_ptr_we_out && ptr_data_out == $past(reg_ptr_in, 2))
    else $error("register tail load wrong");
endmodule // vcps_exec_monitor
`default_nettype wire

/* test/vcps_synth_model.sv */
// behavioural voice engine that reports play state per channel
`timescale 1ns/10ps
`default_nettype none
module vcps_synth_model
(
  input wire logic mclk_in, // clock
  input wire logic reset_n_in, // reset
  input wire logic stop_in, // stop target
  input wire logic start_in, // start head
  input wire logic [2:0] chan_in, // target
  input wire logic [7:0] tail_set_in, // bench starts tails
  output logic [7:0] head_out, // head playing
  output logic [7:0] tail_out // tail playing
);
  always @(posedge mclk_in or negedge reset_n_in)
    if (!reset_n_in)
    begin
      head_out <= 8'h00;
      tail_out <= 8'h00;
    end
    else
    begin
      tail_out <= tail_out | tail_set_in;
      // stop wins over a tail start in the same cycle
      if (stop_in)
      begin
        head_out[chan_in] <= 1'b0;
        tail_out[chan_in] <= 1'b0;
      end
      if (start_in)
        head_out[chan_in] <= 1'b1;
    end
endmodule // vcps_synth_model
`default_nettype wire

/* test/vcps_exec_tb.sv */
// self-checking bench for the voice play and skip unit
`timescale 1ns/10ps
`default_nettype none
module vcps_exec_tb;
  logic mclk_in, reset_n_in, op_valid_in;
  logic [3:0] op_code_in;
  logic [2:0] channel_select_in, target_chan_out;
  logic [10:0] operand_in;
  logic [21:0] reg_ptr_in, ptr_data_out;
  logic [1:0] next_words_in;
  logic [7:0] head_active_in, tail_active_in, tail_set;
  logic busy_out, skip_out, discard_out, stop_out, start_head_out;
  logic head_ptr_we_out, tail_ptr_we_out;
  logic [11:0] chan_data_out;
  int err_total = 0;
  int cmp_count = 0;

  vcps_exec u_dut (.*);
  vcps_synth_model u_syn (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
    .stop_in(stop_out), .start_in(start_head_out), .chan_in(target_chan_out),
    .tail_set_in(tail_set), .head_out(head_active_in),
    .tail_out(tail_active_in));

  initial
  begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  // ------------------------------------------------
  // checking helpers
  // ------------------------------------------------
  task automatic chk(input logic [21:0] got, input logic [21:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic end_sim;
    $display("compares=%0d errors=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic skip_op(input logic [3:0] code, input logic exp);
    int n = 0;
    op_code_in = code;
    // following length 1..3 varies with the code
    next_words_in = 2'(code % 3 + 1);
    op_valid_in = 1'b1;
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    chk(skip_out, exp);
    chk(discard_out, exp);
    while (busy_out === 1'b1 && n < 8)
    begin
      n++;
      @(negedge mclk_in);
    end
    if (n == 8)
    begin
      err_total++;
      end_sim;
    end
    else
    begin
      chk(22'(n), exp ? 22'(code % 3 + 1) : 22'h0);
      // an idle edge keeps the strobe from being lowered and raised at once
      @(negedge mclk_in);
    end
  endtask

  task automatic skip_all(input logic [2:0] ch, input logic [4:0] mask);
    channel_select_in = ch;
    for (int k = 1; k <= 5; k++)
      skip_op(4'(k), mask[k-1]);
  endtask

  task automatic imm_op(input logic [3:0] code, input logic [2:0] ch,
    input logic [21:0] p);
    channel_select_in = ch;
    op_code_in = code;
    op_valid_in = 1'b1;
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    operand_in = p[21:11];
    chk(stop_out, code != 4'h7);
    @(negedge mclk_in);
    operand_in = p[10:0];
    @(negedge mclk_in);
    operand_in = ~p[10:0];
    @(negedge mclk_in);
    chk({head_ptr_we_out, start_head_out, tail_ptr_we_out, busy_out},
      {code == 4'h7, code == 4'h7, code == 4'h8, 1'b0});
    chk(ptr_data_out, p);
    chk(target_chan_out, ch);
  endtask

  task automatic stop_op(input logic [3:0] code, input logic [2:0] ch);
    channel_select_in = ch;
    op_code_in = code;
    reg_ptr_in = 22'h2a5c3e;
    op_valid_in = 1'b1;
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    reg_ptr_in = 22'h15a3c1;
    chk({stop_out, chan_data_out, target_chan_out},
      {1'b1, 12'h800, ch});
    @(negedge mclk_in);
    chk(head_active_in[ch] | tail_active_in[ch], 1'b0);
    chk({tail_ptr_we_out, busy_out}, {code == 4'h9, 1'b0});
    if (code == 4'h9)
      chk(ptr_data_out, 22'h2a5c3e);
  endtask

  initial
  begin
    reset_n_in = 1'b0;
    op_valid_in = 1'b0;
    op_code_in = 4'h0;
    channel_select_in = 3'h0;
    operand_in = 11'h000;
    reg_ptr_in = 22'h000000;
    next_words_in = 2'h1;
    tail_set = 8'h00;
    repeat (4) @(negedge mclk_in);
    reset_n_in = 1'b1;
    skip_all(3'h2, 5'b01101);
    // tail loaded before the play so it does not stop the new voice;
    // channel 2 is idle here, so the tail load may stop the channel
    imm_op(4'h8, 3'h2, 22'h3fffff);
    imm_op(4'h7, 3'h2, 22'h2aa555);
    // the engine takes the start pulse at the next edge
    @(negedge mclk_in);
    chk(head_active_in[2], 1'b1);
    skip_all(3'h2, 5'b10010);
    skip_all(3'h3, 5'b01001);
    tail_set = 8'h20;
    @(negedge mclk_in);
    tail_set = 8'h00;
    skip_all(3'h5, 5'b01010);
    stop_op(4'h9, 3'h5);
    stop_op(4'h6, 3'h2);
    skip_op(4'h3, 1'b1);
    end_sim;
  end
endmodule // vcps_exec_tb

bind vcps_exec vcps_exec_monitor #(.CHANNELS(CHANNELS), .CH_W(CH_W))
  u_mon (.*);
`default_nettype wire
